// *** hdl/oasd_defines.vh ***
// Purpose: Constants of the operand address space decoder
// Assumes: 8-bit core, one core clock domain
// Notes:   Included by every design file of the block
//
// What this block does
// RQ1 - Direct upper half selects special function space
// RQ2 - Lower half reaches RAM, direct or indirect
// RQ3 - Indirect upper half reaches RAM, never registers
// RQ4 - Extended RAM 256 bytes, no off-chip access
// RQ5 - Extended direct uses data pointer, four cycles
// RQ6 - Extended indirect pointer reaches whole extended RAM
// RQ7 - Code read at base plus accumulator, four cycles
// RQ8 - Code in 16 KB flash, nothing external
// RQ9 - Immediate literal fetched after opcode, slower
// RQ10 - Most operations take one or two cycles
// RQ11 - Pointer add two cycles, register add one
// RQ12 - Extended RAM usable only when config is 01
`ifndef OASD_DEFINES_VH
`define OASD_DEFINES_VH

// Addressing modes
`define OASD_M_REG       3'h0
`define OASD_M_DIR       3'h1
`define OASD_M_IND       3'h2
`define OASD_M_IMM       3'h3
`define OASD_M_XDIR      3'h4
`define OASD_M_XIND      3'h5
`define OASD_M_CODE      3'h6

// Core clock cycles per mode
`define OASD_CYC_REG     3'h1
`define OASD_CYC_DIR     3'h2
`define OASD_CYC_IND     3'h2
`define OASD_CYC_IMM     3'h2
`define OASD_CYC_EXTENDED_DATA_RAM    3'h4
`define OASD_CYC_CODE    3'h4

// Spaces
`define OASD_EXTENDED_DATA_RAM_AW     8
`define OASD_CODE_AW     14
`define OASD_SFR_BIT     7
`define OASD_EXTENDED_DATA_RAM_ON     2'h1
`define OASD_CLK_NS      100

`endif

// *** hdl/oasd_extended_data_ram.v ***
// Purpose: Extended data RAM array, registered read
// Assumes: One access per cycle
// Notes:   Read data appear the cycle after the enable
`timescale 1ns/100ps
`include "oasd_defines.vh"
module oasd_extended_data_ram
#(
  parameter AW = `OASD_EXTENDED_DATA_RAM_AW,
  parameter DW = 8
)
(
  input  wire          ref_clk,  // Core clock
  input  wire          en,       // Access enable
  input  wire          we,       // Write when high
  input  wire [AW-1:0] addr,     // Byte address
  input  wire [DW-1:0] wdata,    // Write data
  output wire [DW-1:0] rdata     // Registered read data
);

  reg [DW-1:0] mem_r [0:(1<<AW)-1];
  reg [DW-1:0] rdata_r;

  // Contents are not reset, as in a real array
  always @(posedge ref_clk)
  begin
    if (en && we)
      mem_r[addr] <= wdata;
    if (en)
      rdata_r <= mem_r[addr];
  end

  assign rdata = rdata_r;

endmodule // oasd_extended_data_ram

// *** hdl/oasd_decoder.v ***
// Purpose: Operand address space decoder of the core
// Assumes: Arrays outside answer combinationally in the strobe cycle
// Notes:   Operation runs cycles 0..N-1, done pulses in cycle N
`timescale 1ns/100ps
`include "oasd_defines.vh"
module oasd_decoder
#(
  parameter EXTENDED_DATA_RAM_AW = `OASD_EXTENDED_DATA_RAM_AW,
  parameter CODE_AW = `OASD_CODE_AW
)
(
  input  wire               ref_clk,          // Core clock, 10 MHz
  input  wire               rstn,             // Sync reset, active low
  input  wire               op_start,         // Operand request pulse
  input  wire [2:0]         op_mode,          // Addressing mode
  input  wire [7:0]         op_addr,          // Direct or register address
  input  wire               op_wr,            // Write operand
  input  wire [7:0]         op_wdata,         // Write data
  input  wire [15:0]        data_pointer,     // 16-bit data pointer
  input  wire [7:0]         pointer_register, // 8-bit pointer register
  input  wire [7:0]         acc_value,        // Accumulator
  input  wire [15:0]        prog_counter,     // Address of opcode
  input  wire [1:0]         cfg_extended_data_ram_mode,    // Config bits [1:0]
  input  wire [7:0]         iram_rdata,       // RAM read data
  input  wire [7:0]         sfr_rdata,        // Special function read data
  input  wire [7:0]         code_rdata,       // Flash read data
  output wire               op_busy,          // Operation in progress
  output wire               op_done,          // End of operation pulse
  output wire               acc_load,         // Load op_rdata to accumulator
  output wire [7:0]         op_rdata,         // Operand read data
  output wire               err_extended_data_ram_off,     // Extended RAM not enabled
  output wire               err_extended_data_ram_range,   // Pointer beyond extended RAM
  output wire               err_code_range,   // Code address beyond flash
  output wire               iram_sel,         // RAM strobe
  output wire               sfr_sel,          // Special function strobe
  output wire [7:0]         mem_addr,         // RAM or register address
  output wire               mem_we,           // Write strobe qualifier
  output wire [7:0]         mem_wdata,        // RAM or register write data
  output wire               code_sel,         // Flash read strobe
  output wire [CODE_AW-1:0] code_addr         // Flash byte address
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  reg  [1:0]  st_r;
  reg  [1:0]  st_nxt;
  reg  [2:0]  k_r;
  reg  [2:0]  k_nxt;
  reg  [2:0]  mode_r;
  reg  [7:0]  addr_r;
  reg         wr_r;
  reg  [7:0]  wdat_r;
  reg  [15:0] data_pointer_r;
  reg  [7:0]  ptr_r;
  reg  [7:0]  acc_r;
  reg  [15:0] pc_r;
  reg         done_r;
  reg         accld_r;
  reg  [7:0]  rdata_r;
  reg         exoff_r;
  reg         exrng_r;
  reg         ecrng_r;
  reg  [7:0]  rd_mux;

  wire        idle;
  wire        take;
  wire        act;
  wire [2:0]  cur_mode;
  wire [7:0]  cur_addr;
  wire        cur_wr;
  wire [7:0]  cur_wdat;
  wire [15:0] cur_data_pointer;
  wire [7:0]  cur_ptr;
  wire [7:0]  cur_acc;
  wire [15:0] cur_pc;
  wire [2:0]  cur_k;
  wire [2:0]  cost;
  wire        last;
  wire        is_x;
  wire        is_code;
  wire        is_imm;
  wire [15:0] xaddr;
  wire        x_on;
  wire        x_in;
  wire        x_en;
  wire [7:0]  x_rdata;
  wire [16:0] csum;
  wire [15:0] psum;
  wire        c_in;

  function [2:0] cost_of;
    input [2:0] m;
    begin
      case (m)
        `OASD_M_REG:  cost_of = `OASD_CYC_REG;
        `OASD_M_DIR:  cost_of = `OASD_CYC_DIR;
        `OASD_M_IND:  cost_of = `OASD_CYC_IND;
        `OASD_M_IMM:  cost_of = `OASD_CYC_IMM;
        `OASD_M_XDIR: cost_of = `OASD_CYC_EXTENDED_DATA_RAM;
        `OASD_M_XIND: cost_of = `OASD_CYC_EXTENDED_DATA_RAM;
        `OASD_M_CODE: cost_of = `OASD_CYC_CODE;
        default:      cost_of = `OASD_CYC_REG;
      endcase
    end
  endfunction

  assign idle = st_r[0];
  assign take = idle & op_start;
  assign act  = take | ~idle;

  // Cycle 0 works from the live inputs, later cycles from the latch
  assign cur_mode = idle ? op_mode          : mode_r;
  assign cur_addr = idle ? op_addr          : addr_r;
  assign cur_wr   = idle ? op_wr            : wr_r;
  assign cur_wdat = idle ? op_wdata         : wdat_r;
  assign cur_data_pointer = idle ? data_pointer     : data_pointer_r;
  assign cur_ptr  = idle ? pointer_register : ptr_r;
  assign cur_acc  = idle ? acc_value        : acc_r;
  assign cur_pc   = idle ? prog_counter     : pc_r;
  assign cur_k    = idle ? 3'h0             : k_r;

  // RQ10 one or two cycles
  // RQ11 pointer add costs two
  assign cost = cost_of(cur_mode);
  assign last = act & (cur_k == (cost - 3'h1));

  assign is_x    = (cur_mode == `OASD_M_XDIR) | (cur_mode == `OASD_M_XIND);
  assign is_code = (cur_mode == `OASD_M_CODE);
  assign is_imm  = (cur_mode == `OASD_M_IMM);

  // RQ5 address from data pointer
  // RQ6 8-bit pointer covers all
  assign xaddr = (cur_mode == `OASD_M_XDIR) ? cur_data_pointer : {8'h00, cur_ptr};
  // RQ12 enable code must be 01
  assign x_on  = (cfg_extended_data_ram_mode == `OASD_EXTENDED_DATA_RAM_ON);
  assign x_in  = (xaddr[15:EXTENDED_DATA_RAM_AW] == {(16-EXTENDED_DATA_RAM_AW){1'b0}});
  // Array read registered, so strobe one cycle before the last
  assign x_en  = act & is_x & x_on & x_in & (cur_k == (cost - 3'h2));

  // RQ4 on-chip array only
  oasd_extended_data_ram
  #(
    .AW (EXTENDED_DATA_RAM_AW),
    .DW (8)
  )
  u_extended_data_ram
  (
    .ref_clk (ref_clk),
    .en      (x_en),
    .we      (cur_wr),
    .addr    (xaddr[EXTENDED_DATA_RAM_AW-1:0]),
    .wdata   (cur_wdat),
    .rdata   (x_rdata)
  );

  // RQ7 base plus accumulator
  assign csum = {1'b0, cur_data_pointer} + {9'h000, cur_acc};
  // RQ9 literal follows the opcode
  assign psum = cur_pc + 16'h0001;
  // RQ8 flash space bound
  assign c_in = is_code ? (csum[16:CODE_AW] == {(17-CODE_AW){1'b0}})
                        : (psum[15:CODE_AW] == {(16-CODE_AW){1'b0}});

  // Out-of-range code reads are dropped, never sent outward
  assign code_sel  = last & (is_code | is_imm) & c_in;
  assign code_addr = is_code ? csum[CODE_AW-1:0] : psum[CODE_AW-1:0];

  // RQ2 lower half to RAM
  // RQ3 indirect never hits registers
  assign iram_sel = last & ((cur_mode == `OASD_M_REG) | (cur_mode == `OASD_M_IND) |
                            ((cur_mode == `OASD_M_DIR) & ~cur_addr[`OASD_SFR_BIT]));
  // RQ1 direct upper half
  assign sfr_sel  = last & (cur_mode == `OASD_M_DIR) & cur_addr[`OASD_SFR_BIT];

  assign mem_addr  = (cur_mode == `OASD_M_IND) ? cur_ptr : cur_addr;
  assign mem_we    = (iram_sel | sfr_sel) & cur_wr;
  assign mem_wdata = cur_wdat;

  always @*
  begin
    rd_mux = 8'h00;
    if (sfr_sel)
      rd_mux = sfr_rdata;
    else if (iram_sel)
      rd_mux = iram_rdata;
    else if (code_sel)
      rd_mux = code_rdata;
    else if (is_x & x_on & x_in)
      rd_mux = x_rdata;
  end

  always @*
  begin
    st_nxt = st_r;
    k_nxt  = k_r;
    case (st_r)
      ST_IDLE:
      begin
        k_nxt = 3'h1;
        if (take && !last)
          st_nxt = ST_RUN;
      end
      ST_RUN:
      begin
        k_nxt = k_r + 3'h1;
        if (last)
          st_nxt = ST_IDLE;
      end
      default:
      begin
        st_nxt = ST_IDLE;
        k_nxt  = 3'h0;
      end
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      st_r    <= ST_IDLE;
      k_r     <= 3'h0;
      mode_r  <= 3'h0;
      addr_r  <= 8'h00;
      wr_r    <= 1'b0;
      wdat_r  <= 8'h00;
      data_pointer_r  <= 16'h0000;
      ptr_r   <= 8'h00;
      acc_r   <= 8'h00;
      pc_r    <= 16'h0000;
      done_r  <= 1'b0;
      accld_r <= 1'b0;
      rdata_r <= 8'h00;
      exoff_r <= 1'b0;
      exrng_r <= 1'b0;
      ecrng_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      k_r  <= k_nxt;
      if (take)
      begin
        mode_r <= op_mode;
        addr_r <= op_addr;
        wr_r   <= op_wr;
        wdat_r <= op_wdata;
        data_pointer_r <= data_pointer;
        ptr_r  <= pointer_register;
        acc_r  <= acc_value;
        pc_r   <= prog_counter;
      end
      done_r  <= last;
      // RQ7 result goes to accumulator
      accld_r <= last & is_code;
      exoff_r <= last & is_x & ~x_on;
      exrng_r <= last & is_x & x_on & ~x_in;
      ecrng_r <= last & (is_code | is_imm) & ~c_in;
      if (last && !cur_wr)
        rdata_r <= rd_mux;
    end
  end

  assign op_busy        = act;
  assign op_done        = done_r;
  assign acc_load       = accld_r;
  assign op_rdata       = rdata_r;
  assign err_extended_data_ram_off   = exoff_r;
  assign err_extended_data_ram_range = exrng_r;
  assign err_code_range = ecrng_r;

endmodule // oasd_decoder

// *** testbench/oasd_chk.sv ***
// Purpose: Port assertions of the operand decoder
// Assumes: One clock, sync active-low reset
// Notes:   Bound below the module
`timescale 1ns/100ps
`include "oasd_defines.vh"
module oasd_chk
(
  input logic       ref_clk,          // Clock
  input logic       rstn,             // Reset
  input logic       op_start,         // Request
  input logic [2:0] op_mode,          // Mode
  input logic [7:0] op_addr,          // Address
  input logic [7:0] pointer_register, // Pointer
  input logic [1:0] cfg_extended_data_ram_mode,    // Config
  input logic       op_busy,          // Busy
  input logic       op_done,          // Done
  input logic       acc_load,         // Acc load
  input logic       err_extended_data_ram_off,     // Config error
  input logic       iram_sel,         // RAM strobe
  input logic       sfr_sel,          // Reg strobe
  input logic       code_sel,         // Flash strobe
  input logic [7:0] mem_addr          // Mem address
);
  logic busy_q;
  wire  take = op_start & (op_done | ~busy_q);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Busy seen last cycle tells a taken start from an ignored one
  always @(posedge ref_clk)
    busy_q <= rstn & op_busy;
  a_dir_upper: assert property (take && op_mode == `OASD_M_DIR && op_addr[7] |=>
    sfr_sel && !iram_sel && mem_addr == $past(op_addr)) else $error("direct upper not register");
  a_dir_lower: assert property (take && op_mode == `OASD_M_DIR && !op_addr[7] |=>
    iram_sel && !sfr_sel) else $error("direct lower not RAM");
  a_ind_ram: assert property (take && op_mode == `OASD_M_IND |=>
    iram_sel && !sfr_sel && mem_addr == $past(pointer_register)) else $error("indirect not RAM");
  a_ext_quiet: assert property (take && op_mode[2:1] == 2'b10 |=>
    !(iram_sel || sfr_sel || code_sel) [*3]) else $error("extended op hit other space");
  a_ext_four: assert property (take && op_mode == `OASD_M_XDIR |=>
    !op_done [*3] ##1 op_done) else $error("extended move not four cycles");
  a_code_four: assert property (take && op_mode == `OASD_M_CODE |=>
    !op_done [*3] ##1 op_done) else $error("code read not four cycles");
  a_imm_two: assert property (take && op_mode == `OASD_M_IMM |=>
    op_busy ##1 op_done) else $error("immediate not two cycles");
  a_reg_one: assert property (take && op_mode == `OASD_M_REG |->
    iram_sel ##1 op_done) else $error("register op not one cycle");
  a_cfg_off: assert property (take && op_mode[2:1] == 2'b10 && cfg_extended_data_ram_mode != 2'h1 |->
    ##4 op_done && err_extended_data_ram_off) else $error("extended op while disabled");
  c_sfr: cover property (sfr_sel);
  c_acc: cover property (acc_load);
  c_off: cover property (err_extended_data_ram_off);
endmodule // oasd_chk
bind oasd_decoder oasd_chk i_chk (.ref_clk(ref_clk), .rstn(rstn), .op_start(op_start),
  .op_mode(op_mode), .op_addr(op_addr), .pointer_register(pointer_register),
  .cfg_extended_data_ram_mode(cfg_extended_data_ram_mode), .op_busy(op_busy), .op_done(op_done), .acc_load(acc_load),
  .err_extended_data_ram_off(err_extended_data_ram_off), .iram_sel(iram_sel), .sfr_sel(sfr_sel), .code_sel(code_sel),
  .mem_addr(mem_addr));

// *** testbench/oasd_mem_model.sv ***
// Purpose: RAM, register space and flash behind the decoder
// Assumes: Reads answer in the strobe cycle
// Notes:   Unselected outputs toggle every cycle
`timescale 1ns/100ps
module oasd_mem_model
(
  input  logic        ref_clk,    // Clock
  input  logic        iram_sel,   // RAM strobe
  input  logic        sfr_sel,    // Reg strobe
  input  logic        mem_we,     // Write
  input  logic [7:0]  mem_addr,   // Address
  input  logic [7:0]  mem_wdata,  // Write data
  input  logic        code_sel,   // Flash strobe
  input  logic [13:0] code_addr,  // Flash address
  output logic [7:0]  iram_rdata, // RAM data
  output logic [7:0]  sfr_rdata,  // Reg data
  output logic [7:0]  code_rdata  // Flash data
);
  logic [7:0] ram [256];
  logic [7:0] regs [128];
  logic [7:0] junk = 8'h5a;
  initial
    for (int i = 0; i < 256; i++)
    begin
      ram[i] = 8'(i) ^ 8'ha5;
      regs[i % 128] = ~8'(i);
    end
  always @(posedge ref_clk)
  begin
    junk <= {junk[6:0], ~junk[7]};
    if (iram_sel && mem_we)
      ram[mem_addr] <= mem_wdata;
    if (sfr_sel && mem_we)
      regs[mem_addr[6:0]] <= mem_wdata;
  end
  assign iram_rdata = iram_sel ? ram[mem_addr] : junk;
  assign sfr_rdata = sfr_sel ? regs[mem_addr[6:0]] : ~junk;
  assign code_rdata = code_sel ? code_addr[7:0] ^ {2'h0, code_addr[13:8]} ^ 8'h69 : junk;
endmodule // oasd_mem_model

// *** testbench/operand_address_space_decoder_tb.sv ***
// Purpose: Self-checking bench of the operand decoder
// Assumes: Model arrays start from fixed patterns
// Notes:   Extended RAM filled first, so every read is known
`timescale 1ns/100ps
module operand_address_space_decoder_tb;
  logic        ref_clk = 0, rstn = 0, op_start = 0, op_wr = 0;
  logic [2:0]  op_mode = 0;
  logic [7:0]  op_addr = 0, op_wdata = 0, pointer_register = 0, acc_value = 0;
  logic [15:0] data_pointer = 0, prog_counter = 0;
  logic [1:0]  cfg_extended_data_ram_mode = 1;
  wire  [7:0]  ird, srd, crd, op_rdata, ma, mwd;
  wire         op_busy, op_done, acc_load, e_off, e_rng, e_code, isel, ssel, mwe, csel;
  wire  [13:0] ca;
  logic [7:0]  ram_s [256], reg_s [128], ext_s [256];
  logic [31:0] lf = 32'h5c41_af50, r;
  int          bad_count = 0, cmp_count = 0, cyc = 0;
  oasd_decoder i_dut (.ref_clk(ref_clk), .rstn(rstn), .op_start(op_start), .op_mode(op_mode),
    .op_addr(op_addr), .op_wr(op_wr), .op_wdata(op_wdata), .data_pointer(data_pointer),
    .pointer_register(pointer_register), .acc_value(acc_value), .prog_counter(prog_counter),
    .cfg_extended_data_ram_mode(cfg_extended_data_ram_mode), .iram_rdata(ird), .sfr_rdata(srd), .code_rdata(crd),
    .op_busy(op_busy), .op_done(op_done), .acc_load(acc_load), .op_rdata(op_rdata),
    .err_extended_data_ram_off(e_off), .err_extended_data_ram_range(e_rng), .err_code_range(e_code), .iram_sel(isel),
    .sfr_sel(ssel), .mem_addr(ma), .mem_we(mwe), .mem_wdata(mwd), .code_sel(csel), .code_addr(ca));
  oasd_mem_model i_mem (.ref_clk(ref_clk), .iram_sel(isel), .sfr_sel(ssel), .mem_we(mwe),
    .mem_addr(ma), .mem_wdata(mwd), .code_sel(csel), .code_addr(ca), .iram_rdata(ird),
    .sfr_rdata(srd), .code_rdata(crd));
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      results;
    end
  end
  function automatic [7:0] cpat(input [15:0] a);
    return a[7:0] ^ {2'h0, a[13:8]} ^ 8'h69;
  endfunction
  function automatic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  task automatic ck(input logic [7:0] g, e);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic op(input [2:0] m, input [7:0] a, input w, input [7:0] d, input [15:0] dp,
    input [7:0] p, c);
    int n;
    logic [7:0] ex;
    logic [2:0] er;
    logic ok;
    ok = cfg_extended_data_ram_mode == 2'h1;
    er = 0;
    ex = 0;
    case (m)
      0: ex = ram_s[a];
      1: ex = a[7] ? reg_s[a[6:0]] : ram_s[a];
      2: ex = ram_s[p];
      3: er[2] = prog_counter >= 16'h3fff;
      4: er[1:0] = {ok && dp[15:8] != 0, !ok};
      5: er[0] = !ok;
      6: er[2] = {1'b0, dp} + c >= 17'h0_4000;
    endcase
    if (m == 3 && !er[2]) ex = cpat(prog_counter + 1);
    if (m == 6 && !er[2]) ex = cpat(dp + c);
    if (m == 4 && er == 0) ex = ext_s[dp[7:0]];
    if (m == 5 && er == 0) ex = ext_s[p];
    {op_mode, op_addr, op_wr, op_wdata, data_pointer, pointer_register, acc_value} =
      {m, a, w, d, dp, p, c};
    op_start = 1;
    @(posedge ref_clk);
    #1 op_start = 0;
    for (n = 1; !op_done && n < 9; n++)
      @(posedge ref_clk) #1;
    ck(8'(n), m == 0 ? 8'h01 : m < 4 ? 8'h02 : 8'h04);
    if (!w) ck(op_rdata, ex);
    // Code reads load the accumulator even when out of range, with zero data
    ck({5'h0, acc_load, e_rng, e_off}, {5'h0, m == 6, er[1:0]});
    ck({7'h0, e_code}, {7'h0, er[2]});
    if (w && m < 3 && (m != 1 || !a[7])) ram_s[m == 2 ? p : a] = d;
    if (w && m == 1 && a[7]) reg_s[a[6:0]] = d;
    if (w && m[2:1] == 2'b10 && er == 0) ext_s[m == 4 ? dp[7:0] : p] = d;
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      ram_s[i] = 8'(i) ^ 8'ha5;
      reg_s[i % 128] = ~8'(i);
    end
    repeat (10) @(posedge ref_clk);
    #1 rstn = 1;
    @(posedge ref_clk) #1;
    for (int i = 0; i < 256; i++)
      op(5, 0, 1, 8'(i) ^ 8'h3c, 0, 8'(i), 0);
    op(1, 8'h90, 1, 8'h11, 0, 0, 0);
    op(1, 8'h90, 0, 0, 0, 0, 0);
    op(2, 0, 0, 0, 0, 8'h90, 0);
    op(2, 0, 1, 8'h77, 0, 8'h7f, 0);
    op(1, 8'h7f, 0, 0, 0, 0, 0);
    op(0, 8'h05, 0, 0, 0, 0, 0);
    op(4, 0, 0, 0, 16'h00ff, 0, 0);
    op(4, 0, 0, 0, 16'h0100, 0, 0);
    for (int i = 0; i < 4; i++)
    begin
      cfg_extended_data_ram_mode = 2'(i);
      op(5, 0, 1, 8'h99, 0, 8'h80, 0);
      op(4, 0, 0, 0, 16'h0080, 0, 0);
    end
    op(6, 0, 0, 0, 16'h3f00, 0, 8'hff);
    op(6, 0, 0, 0, 16'h3fff, 0, 8'h01);
    prog_counter = 16'h3ffe;
    op(3, 0, 0, 0, 0, 0, 0);
    prog_counter = 16'h3fff;
    op(3, 0, 0, 0, 0, 0, 0);
    $display("corner test done");
    repeat (600)
    begin
      r = rnd();
      cfg_extended_data_ram_mode = r[6:4] == 0 ? r[8:7] : 2'h1;
      prog_counter = {2'h0, r[29:16]};
      op(r[2:0] % 7, r[15:8], r[3] && r[2:0] % 7 != 3 && r[2:0] % 7 != 6, r[23:16],
        r[11] ? r[31:16] : {8'h0, r[31:24]}, r[27:20], r[19:12]);
    end
    $display("random test done");
    results;
  end
endmodule // operand_address_space_decoder_tb
